// File: inc/frc_pkg.sv
// shared constants and carriers for the flash rewrite control block
`default_nettype none
package frc_pkg;
  localparam logic [8:0] FRC_ADDR_CTRL0 = 9'h1B4;
  localparam logic [8:0] FRC_ADDR_CTRL1 = 9'h1B5;
  localparam logic [8:0] FRC_ADDR_STATUS = 9'h1B2;
  localparam logic [7:0] FRC_CTRL0_RESET = 8'h00;
  localparam logic [7:0] FRC_CTRL1_RESET = 8'h00;
  // control 0 bit positions
  localparam int FRC_B_REWRITE_EN = 1;
  localparam int FRC_B_ROM_MODE = 2;
  localparam int FRC_B_FLASH_STOP = 3;
  localparam int FRC_B_SEQ_RESET = 4;
  localparam int FRC_B_CMDERR_IE = 5;
  localparam int FRC_B_ACCERR_IE = 6;
  localparam int FRC_B_READY_IE = 7;
  // control 1 bit positions
  localparam int FRC_B_LOCK_DIS = 3;
  localparam int FRC_B_PROT_LO = 4;
  localparam int FRC_NUM_BLOCKS = 4;
  // status register bit positions
  localparam int FRC_B_READY_REQ = 0;
  localparam int FRC_B_ACCERR_REQ = 1;
  localparam int FRC_B_READY_BUSY = 7;
  // stop-to-ready delay after a sequence reset
  localparam int FRC_CLK_MHZ = 20;
  localparam int FRC_STOP_TO_READY_NS = 1000;
  localparam int FRC_STOP_TO_READY_CYC = (FRC_STOP_TO_READY_NS * FRC_CLK_MHZ + 999) / 1000;

  // events reported by the flash sequencer
  typedef struct packed {
    logic busy;
    logic prog_done;
    logic erase_done;
    logic seq_error;
    logic cmd_error;
    logic suspend_entry;
    logic access_busy_blk;
  } frc_seq_evt_t;

  // controls driven toward the flash array and sequencer
  typedef struct packed {
    logic cmd_accept;
    logic rom_mode;
    logic flash_stop;
    logic force_abort;
    logic clear_suspend;
    logic lock_override;
    logic [3:0] block_protect;
  } frc_flash_ctl_t;

  typedef enum logic [1:0] {FRC_IDLE, FRC_ABORTING, FRC_RELEASE} frc_abort_state_t;
endpackage
`default_nettype wire

// File: rtl/frc_unlock_seq.sv
// two-write unlock detector for a guarded control bit
`timescale 1ns/1ns
`default_nettype none
module frc_unlock_seq #(
  parameter bit ARM_VALUE = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr,
  input wire logic other_wr,
  input wire logic wdata_bit,
  output logic armed
);
  logic armed_r;
  logic armed_nxt;
  // arming holds only until the very next register write of any kind
  assign armed_nxt = (wr && (wdata_bit == ARM_VALUE)) ? 1'b1 : ((wr || other_wr) ? 1'b0 : armed_r);
  assign armed = armed_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= armed_nxt;
    end
  end
endmodule
`default_nettype wire

// File: rtl/frc_abort_timer.sv
// stop-to-ready timer that ends a forced sequence reset
`timescale 1ns/1ns
`default_nettype none
module frc_abort_timer #(
  parameter int CYCLES = frc_pkg::FRC_STOP_TO_READY_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  output logic active,
  output logic done
);
  frc_pkg::frc_abort_state_t state_r;
  frc_pkg::frc_abort_state_t state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  localparam logic [15:0] LAST = 16'(CYCLES - 1);
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      frc_pkg::FRC_IDLE: begin
        if (start) begin
          state_nxt = frc_pkg::FRC_ABORTING;
          cnt_nxt = 16'h0000;
        end
      end
      frc_pkg::FRC_ABORTING: begin
        if (cnt_r == LAST) begin
          state_nxt = frc_pkg::FRC_RELEASE;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      default: begin
        state_nxt = frc_pkg::FRC_IDLE;
      end
    endcase
  end
  assign active = (state_r == frc_pkg::FRC_ABORTING);
  assign done = (state_r == frc_pkg::FRC_RELEASE);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= frc_pkg::FRC_IDLE;
      cnt_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// File: rtl/frc_flash_rewrite_control.sv
// flash rewrite control registers with interrupt request flags
`timescale 1ns/1ns
`default_nettype none
module frc_flash_rewrite_control #(
  parameter int ABORT_CYCLES = frc_pkg::FRC_STOP_TO_READY_CYC
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [8:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire frc_pkg::frc_seq_evt_t SEQ_EVT,
  output frc_pkg::frc_flash_ctl_t FLASH_CTL,
  output logic READY_IRQ,
  output logic ACCESS_ERR_IRQ,
  output logic CMD_ERR_IRQ
);
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl0_nxt;
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl1_nxt;
  logic ready_req_r;
  logic ready_req_nxt;
  logic accerr_req_r;
  logic accerr_req_nxt;
  logic busy_d_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  frc_pkg::frc_flash_ctl_t ctl_r;
  frc_pkg::frc_flash_ctl_t ctl_nxt;
  logic ready_irq_r;
  logic accerr_irq_r;
  logic cmderr_irq_r;

  // address decode
  wire wr0 = WR && (ADDR == frc_pkg::FRC_ADDR_CTRL0);
  wire wr1 = WR && (ADDR == frc_pkg::FRC_ADDR_CTRL1);
  wire wrs = WR && (ADDR == frc_pkg::FRC_ADDR_STATUS);
  wire rd0 = RD && (ADDR == frc_pkg::FRC_ADDR_CTRL0);
  wire rd1 = RD && (ADDR == frc_pkg::FRC_ADDR_CTRL1);
  wire rds = RD && (ADDR == frc_pkg::FRC_ADDR_STATUS);

  wire rewrite_en = ctrl0_r[frc_pkg::FRC_B_REWRITE_EN];
  wire busy = SEQ_EVT.busy;
  wire abort_active;
  wire abort_done;

  // guarded set and clear sequences; any other register write breaks the arming
  wire arm_en;
  wire arm_rom;
  wire arm_lock;
  logic [frc_pkg::FRC_NUM_BLOCKS-1:0] arm_prot;
  frc_unlock_seq #(.ARM_VALUE(1'b0)) u_arm_en (
    .clk(CLK), .reset_n(RESET_N), .wr(wr0), .other_wr(WR && !wr0),
    .wdata_bit(WDATA[frc_pkg::FRC_B_REWRITE_EN]), .armed(arm_en));
  frc_unlock_seq #(.ARM_VALUE(1'b0)) u_arm_rom (
    .clk(CLK), .reset_n(RESET_N), .wr(wr0), .other_wr(WR && !wr0),
    .wdata_bit(WDATA[frc_pkg::FRC_B_ROM_MODE]), .armed(arm_rom));
  frc_unlock_seq #(.ARM_VALUE(1'b0)) u_arm_lock (
    .clk(CLK), .reset_n(RESET_N), .wr(wr1), .other_wr(WR && !wr1),
    .wdata_bit(WDATA[frc_pkg::FRC_B_LOCK_DIS]), .armed(arm_lock));
  genvar gi;
  generate
    for (gi = 0; gi < frc_pkg::FRC_NUM_BLOCKS; gi++) begin : g_prot
      frc_unlock_seq #(.ARM_VALUE(1'b1)) u_arm_prot (
        .clk(CLK), .reset_n(RESET_N), .wr(wr1), .other_wr(WR && !wr1),
        .wdata_bit(WDATA[frc_pkg::FRC_B_PROT_LO + gi]), .armed(arm_prot[gi]));
    end
  endgenerate

  // sequence reset accepted only with rewrite enabled and flash busy
  wire seq_reset_go = wr0 && WDATA[frc_pkg::FRC_B_SEQ_RESET] && rewrite_en && busy;
  // rewrite enable dropping, by software write
  wire en_clear = wr0 && !WDATA[frc_pkg::FRC_B_REWRITE_EN] && rewrite_en;
  wire stop_set = wr0 && rewrite_en && WDATA[frc_pkg::FRC_B_FLASH_STOP] && !ctrl0_r[frc_pkg::FRC_B_FLASH_STOP];

  frc_abort_timer #(.CYCLES(ABORT_CYCLES)) u_abort (
    .clk(CLK), .reset_n(RESET_N), .start(seq_reset_go), .active(abort_active), .done(abort_done));

  // control register 0 next value
  always_comb begin
    ctrl0_nxt = ctrl0_r;
    if (wr0) begin
      // enable and mode bits: set needs arming, clear is always allowed
      ctrl0_nxt[frc_pkg::FRC_B_REWRITE_EN] = WDATA[frc_pkg::FRC_B_REWRITE_EN] &
        (arm_en | rewrite_en);
      ctrl0_nxt[frc_pkg::FRC_B_ROM_MODE] = WDATA[frc_pkg::FRC_B_ROM_MODE] &
        (arm_rom | ctrl0_r[frc_pkg::FRC_B_ROM_MODE]);
      if (rewrite_en) begin
        ctrl0_nxt[frc_pkg::FRC_B_FLASH_STOP] = WDATA[frc_pkg::FRC_B_FLASH_STOP];
      end
      ctrl0_nxt[frc_pkg::FRC_B_CMDERR_IE] = WDATA[frc_pkg::FRC_B_CMDERR_IE];
      ctrl0_nxt[frc_pkg::FRC_B_ACCERR_IE] = WDATA[frc_pkg::FRC_B_ACCERR_IE];
      ctrl0_nxt[frc_pkg::FRC_B_READY_IE] = WDATA[frc_pkg::FRC_B_READY_IE];
      ctrl0_nxt[0] = WDATA[0];
    end
    ctrl0_nxt[frc_pkg::FRC_B_SEQ_RESET] = 1'b0;
  end

  // control register 1 next value
  wire lock_clear = SEQ_EVT.prog_done || SEQ_EVT.erase_done || SEQ_EVT.seq_error ||
    SEQ_EVT.suspend_entry || en_clear || stop_set || seq_reset_go;
  always_comb begin
    ctrl1_nxt = ctrl1_r;
    if (wr1) begin
      ctrl1_nxt[frc_pkg::FRC_B_LOCK_DIS] = WDATA[frc_pkg::FRC_B_LOCK_DIS] &
        (arm_lock | ctrl1_r[frc_pkg::FRC_B_LOCK_DIS]);
      for (int i = 0; i < frc_pkg::FRC_NUM_BLOCKS; i++) begin
        // a zero lands only right after a one was written
        ctrl1_nxt[frc_pkg::FRC_B_PROT_LO + i] = WDATA[frc_pkg::FRC_B_PROT_LO + i] |
          !arm_prot[i];
        if (!ctrl1_r[frc_pkg::FRC_B_PROT_LO + i] && !WDATA[frc_pkg::FRC_B_PROT_LO + i]) begin
          ctrl1_nxt[frc_pkg::FRC_B_PROT_LO + i] = 1'b0;
        end
      end
    end
    if (lock_clear) begin
      ctrl1_nxt[frc_pkg::FRC_B_LOCK_DIS] = 1'b0;
    end
    if (en_clear) begin
      ctrl1_nxt[7:4] = 4'h0;
    end
    ctrl1_nxt[2:0] = 3'h0;
  end

  // request flags: hardware set wins over a software clear in the same cycle
  wire ready_edge = busy_d_r && !busy;
  // a command sequence error counts as a command error as well
  wire cmd_fault = SEQ_EVT.cmd_error || SEQ_EVT.seq_error;
  wire accerr_evt = (ctrl0_r[frc_pkg::FRC_B_ACCERR_IE] && SEQ_EVT.access_busy_blk) ||
    (ctrl0_r[frc_pkg::FRC_B_CMDERR_IE] && cmd_fault);
  assign ready_req_nxt = (ready_edge && ctrl0_r[frc_pkg::FRC_B_READY_IE]) ? 1'b1 :
    ((wrs && !WDATA[frc_pkg::FRC_B_READY_REQ]) ? 1'b0 : ready_req_r);
  assign accerr_req_nxt = accerr_evt ? 1'b1 :
    ((wrs && !WDATA[frc_pkg::FRC_B_ACCERR_REQ]) ? 1'b0 : accerr_req_r);

  // read mux, data valid the cycle after the strobe
  wire [7:0] status_view = {!busy, 5'h00, accerr_req_r, ready_req_r};
  assign rdata_nxt = rd0 ? ctrl0_r : (rd1 ? ctrl1_r : (rds ? status_view : 8'h00));

  // controls toward the flash side
  always_comb begin
    ctl_nxt.cmd_accept = ctrl0_nxt[frc_pkg::FRC_B_REWRITE_EN] && !ctrl0_nxt[frc_pkg::FRC_B_FLASH_STOP];
    ctl_nxt.rom_mode = ctrl0_nxt[frc_pkg::FRC_B_ROM_MODE];
    ctl_nxt.flash_stop = ctrl0_nxt[frc_pkg::FRC_B_FLASH_STOP];
    ctl_nxt.force_abort = seq_reset_go || abort_active;
    ctl_nxt.clear_suspend = seq_reset_go;
    ctl_nxt.lock_override = ctrl1_nxt[frc_pkg::FRC_B_LOCK_DIS];
    ctl_nxt.block_protect = ctrl1_nxt[7:4];
  end

  // register state
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl0_r <= frc_pkg::FRC_CTRL0_RESET;
      ctrl1_r <= frc_pkg::FRC_CTRL1_RESET;
      ready_req_r <= 1'b0;
      accerr_req_r <= 1'b0;
      busy_d_r <= 1'b0;
      rdata_r <= 8'h00;
      ctl_r <= '0;
    end else begin
      ctrl0_r <= ctrl0_nxt;
      ctrl1_r <= ctrl1_nxt;
      ready_req_r <= ready_req_nxt;
      accerr_req_r <= accerr_req_nxt;
      busy_d_r <= busy;
      rdata_r <= rdata_nxt;
      ctl_r <= ctl_nxt;
    end
  end

  // interrupt outputs registered from next flag and enable values
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ready_irq_r <= 1'b0;
      accerr_irq_r <= 1'b0;
      cmderr_irq_r <= 1'b0;
    end else begin
      ready_irq_r <= ready_req_nxt && ctrl0_nxt[frc_pkg::FRC_B_READY_IE];
      accerr_irq_r <= accerr_req_nxt && ctrl0_nxt[frc_pkg::FRC_B_ACCERR_IE];
      cmderr_irq_r <= accerr_req_nxt && ctrl0_nxt[frc_pkg::FRC_B_CMDERR_IE];
    end
  end

  assign RDATA = rdata_r;
  assign FLASH_CTL = ctl_r;
  assign READY_IRQ = ready_irq_r;
  assign ACCESS_ERR_IRQ = accerr_irq_r;
  assign CMD_ERR_IRQ = cmderr_irq_r;

  // assertions
  sequence arm_write_s;
    wr0 && !WDATA[frc_pkg::FRC_B_REWRITE_EN];
  endsequence
  sequence set_write_s;
    wr0 && WDATA[frc_pkg::FRC_B_REWRITE_EN];
  endsequence
  en_set_guard_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(ctrl0_r[frc_pkg::FRC_B_REWRITE_EN]) |-> $past(arm_en))
    else $error("rewrite enable set without unlock write");
  en_unlock_seq_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    arm_write_s ##1 set_write_s |=> ctrl0_r[frc_pkg::FRC_B_REWRITE_EN])
    else $error("unlock sequence did not set rewrite enable");
  prot_clear_guard_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    $fell(ctrl1_r[4]) |-> $past(arm_prot[0]) || $past(en_clear))
    else $error("block protect cleared without unlock");
  stop_gate_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (wr0 && !rewrite_en) |=> $stable(ctrl0_r[frc_pkg::FRC_B_FLASH_STOP]))
    else $error("flash stop changed while rewrite disabled");
  seq_reset_zero_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    !ctrl0_r[frc_pkg::FRC_B_SEQ_RESET])
    else $error("sequence reset bit reads nonzero");
  abort_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    seq_reset_go |=> FLASH_CTL.force_abort [*2])
    else $error("force abort not held after sequence reset");
  lock_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (SEQ_EVT.prog_done || seq_reset_go) |=> !ctrl1_r[frc_pkg::FRC_B_LOCK_DIS])
    else $error("lock disable not cleared");
  ready_flag_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (ready_edge && ctrl0_r[frc_pkg::FRC_B_READY_IE]) |=> ready_req_r ##0 READY_IRQ)
    else $error("ready request not raised on busy to ready");
  prot_drop_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    en_clear |=> ctrl1_r[7:4] == 4'h0)
    else $error("protect bits not cleared on rewrite disable");
  mode_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (wr0 && !WDATA[frc_pkg::FRC_B_REWRITE_EN]) |=> !ctrl0_r[frc_pkg::FRC_B_REWRITE_EN])
    else $error("rewrite enable not cleared by a zero write");
  stop_write_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (wr0 && rewrite_en) |=> ctrl0_r[frc_pkg::FRC_B_FLASH_STOP] == $past(WDATA[frc_pkg::FRC_B_FLASH_STOP]))
    else $error("flash stop write ignored while rewrite enabled");
  seq_bit_read_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    rd0 |=> !RDATA[frc_pkg::FRC_B_SEQ_RESET])
    else $error("sequence reset bit read back as one");

  // guarded sequences for the second control register
  sequence prot_arm_s;
    wr1 && WDATA[frc_pkg::FRC_B_PROT_LO];
  endsequence
  sequence prot_clear_s;
    wr1 && !WDATA[frc_pkg::FRC_B_PROT_LO];
  endsequence
  sequence lock_arm_s;
    wr1 && !WDATA[frc_pkg::FRC_B_LOCK_DIS];
  endsequence
  // a completion event in the same cycle must still win over the set
  sequence lock_set_s;
    wr1 && WDATA[frc_pkg::FRC_B_LOCK_DIS] && !lock_clear;
  endsequence
  prot_unlock_seq_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    prot_arm_s ##1 prot_clear_s |=> !ctrl1_r[frc_pkg::FRC_B_PROT_LO])
    else $error("unlock sequence did not clear block protect");
  lock_unlock_seq_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    lock_arm_s ##1 lock_set_s |=> ctrl1_r[frc_pkg::FRC_B_LOCK_DIS])
    else $error("unlock sequence did not set lock disable");
  lock_gate_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (wr1 && !arm_lock && !ctrl1_r[frc_pkg::FRC_B_LOCK_DIS]) |=> !ctrl1_r[frc_pkg::FRC_B_LOCK_DIS])
    else $error("lock disable set without unlock write");
  lock_events_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (SEQ_EVT.erase_done || SEQ_EVT.seq_error || SEQ_EVT.suspend_entry || en_clear || stop_set) |=>
      !ctrl1_r[frc_pkg::FRC_B_LOCK_DIS])
    else $error("lock disable survived a clearing event");

  // forced stop: pulse, hold and release toward the sequencer
  abort_release_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (abort_done && !seq_reset_go) |=> !FLASH_CTL.force_abort)
    else $error("force abort held past the stop-to-ready delay");
  suspend_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    seq_reset_go |=> FLASH_CTL.clear_suspend)
    else $error("suspend clear missing after sequence reset");
  suspend_pulse_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    !seq_reset_go |=> !FLASH_CTL.clear_suspend)
    else $error("suspend clear without sequence reset");
  seq_reset_gate_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    FLASH_CTL.clear_suspend |-> $past(rewrite_en) && $past(busy))
    else $error("sequence reset acted while idle or disabled");

  // registered controls mirror the register bits they come from
  accept_out_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    FLASH_CTL.cmd_accept == (ctrl0_r[frc_pkg::FRC_B_REWRITE_EN] && !ctrl0_r[frc_pkg::FRC_B_FLASH_STOP]))
    else $error("command accept does not follow rewrite enable");
  rom_out_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    FLASH_CTL.rom_mode == ctrl0_r[frc_pkg::FRC_B_ROM_MODE])
    else $error("rom mode output does not follow its bit");
  stop_out_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    FLASH_CTL.flash_stop |-> !FLASH_CTL.cmd_accept)
    else $error("commands accepted while flash stopped");
  lock_out_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    FLASH_CTL.lock_override == ctrl1_r[frc_pkg::FRC_B_LOCK_DIS])
    else $error("lock override does not follow its bit");
  prot_out_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    FLASH_CTL.block_protect == ctrl1_r[7:4])
    else $error("block protect output does not follow its bits");

  // request flags and the interrupt lines built on them
  ready_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (wrs && !WDATA[frc_pkg::FRC_B_READY_REQ] && !ready_edge) |=> !ready_req_r)
    else $error("ready request not cleared by software");
  accerr_set_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (ctrl0_r[frc_pkg::FRC_B_ACCERR_IE] && SEQ_EVT.access_busy_blk && !wr0) |=> accerr_req_r && ACCESS_ERR_IRQ)
    else $error("access error not raised on busy access");
  cmderr_set_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (ctrl0_r[frc_pkg::FRC_B_CMDERR_IE] && cmd_fault && !wr0) |=> accerr_req_r && CMD_ERR_IRQ)
    else $error("command error interrupt not raised");
  ready_irq_flag_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    READY_IRQ |-> ready_req_r)
    else $error("ready interrupt without its request flag");
  err_irq_flag_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (ACCESS_ERR_IRQ || CMD_ERR_IRQ) |-> accerr_req_r)
    else $error("error interrupt without its request flag");
  err_irq_drop_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    (wrs && !WDATA[frc_pkg::FRC_B_ACCERR_REQ] && !accerr_evt) |=> !ACCESS_ERR_IRQ && !CMD_ERR_IRQ)
    else $error("error interrupt stayed after flag clear");
  status_busy_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    rds |=> RDATA[frc_pkg::FRC_B_READY_BUSY] == !$past(busy))
    else $error("status ready bit does not match busy");
endmodule
`default_nettype wire

// File: test/frc_seq_model.sv
// sequencer stand-in that drives the event struct of the rewrite control block
`timescale 1ns/1ns
`default_nettype none
module frc_seq_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire frc_pkg::frc_flash_ctl_t ctl,
  input wire logic go,
  input wire logic [7:0] len,
  input wire logic [5:0] kick,
  output frc_pkg::frc_seq_evt_t evt
);
  logic busy_r;
  logic abort_r;
  logic done_r;
  logic [7:0] cnt_r;
  // a forced stop keeps busy up until the abort window closes, as the real array would
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
      abort_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= 8'h00;
    end else begin
      done_r <= 1'b0;
      if (go && ctl.cmd_accept) begin
        busy_r <= 1'b1;
        cnt_r <= len;
      end else if (busy_r && ctl.force_abort) begin
        abort_r <= 1'b1;
      end else if (busy_r && abort_r) begin
        busy_r <= 1'b0;
        abort_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
  // pulses other than completion are commanded by the bench, one cycle each
  assign evt = {busy_r, done_r | kick[0], kick[1], kick[2], kick[3], kick[4], kick[5]};
endmodule
`default_nettype wire

// File: test/flash_rewrite_control_test.sv
// self-checking bench for the flash rewrite control registers
`timescale 1ns/1ns
`default_nettype none
module flash_rewrite_control_test;
  localparam int AB = 3;
  localparam logic [8:0] C0 = frc_pkg::FRC_ADDR_CTRL0;
  localparam logic [8:0] C1 = frc_pkg::FRC_ADDR_CTRL1;
  localparam logic [8:0] ST = frc_pkg::FRC_ADDR_STATUS;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic go = 1'b0;
  logic [7:0] len = 8'h00;
  logic [5:0] kick = 6'h00;
  logic [7:0] rdata;
  logic rdy;
  logic acc;
  logic cmd;
  logic [7:0] m;
  logic [7:0] exp_q[$];
  frc_pkg::frc_seq_evt_t evt;
  frc_pkg::frc_flash_ctl_t ctl;
  int fails = 0;
  int samples_checked = 0;
  int n;
  logic [7:0] en_t[4] = '{8'h46, 8'h26, 8'h26, 8'h06};
  int src_t[4] = '{5, 3, 2, 5};
  logic [7:0] irq_t[4] = '{8'h02, 8'h01, 8'h01, 8'h00};
  int lk_t[4] = '{0, 1, 2, 4};

  always #25 clk = ~clk;

  frc_flash_rewrite_control #(.ABORT_CYCLES(AB)) frc_flash_rewrite_control_i (.CLK(clk), .RESET_N(reset_n),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SEQ_EVT(evt), .FLASH_CTL(ctl),
    .READY_IRQ(rdy), .ACCESS_ERR_IRQ(acc), .CMD_ERR_IRQ(cmd));
  frc_seq_model frc_seq_model_i (.clk(clk), .reset_n(reset_n), .ctl(ctl), .go(go), .len(len),
    .kick(kick), .evt(evt));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // every bus signal is set once just after an edge and held for the next one
  task automatic bus(input logic w, input logic r, input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
  endtask
  task automatic wreg(input logic [8:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rreg(input logic [8:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(input int k);
    repeat (k) bus(1'b0, 1'b0, 9'h000, 8'h00);
  endtask
  task automatic start(input logic [7:0] l);
    idle(1);
    go <= 1'b1;
    len <= l;
    idle(1);
    go <= 1'b0;
  endtask
  task automatic pulse(input int b);
    idle(1);
    kick <= 6'h01 << b;
    idle(1);
    kick <= 6'h00;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // read data stand only in the cycle after the strobe, so compare at that negedge
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d && exp_q.size() > 0) begin
      check(rdata, exp_q.pop_front());
    end
  end

  initial begin
    #(50 * 4000);
    fails++;
    print_verdict;
  end

  initial begin
    void'($urandom(97637));
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rreg(C0, 8'h00);
    rreg(C1, 8'h00);
    rreg(ST, 8'h80);
    rreg(9'h1B3, 8'h00);
    wreg(C0, 8'h06);
    rreg(C0, 8'h00);
    wreg(C0, 8'h00);
    wreg(C0, 8'h06);
    rreg(C0, 8'h06);
    idle(1);
    @(negedge clk);
    check({6'h00, ctl.cmd_accept, ctl.rom_mode}, 8'h03);
    $display("test unlock done");
    m = {4'($urandom_range(15, 1)), 4'h0};
    wreg(C1, m);
    wreg(C0, 8'h06);
    wreg(C1, 8'h00);
    rreg(C1, m);
    idle(1);
    @(negedge clk);
    check({4'h0, ctl.block_protect}, m >> 4);
    wreg(C1, 8'hF0);
    wreg(C1, 8'h00);
    rreg(C1, 8'h00);
    wreg(C1, 8'h00);
    wreg(C0, 8'h06);
    wreg(C1, 8'h08);
    rreg(C1, 8'h00);
    $display("test protect done");
    for (n = 0; n < 4; n++) begin
      wreg(C1, 8'h00);
      wreg(C1, 8'h08);
      idle(1);
      @(negedge clk);
      check({7'h00, ctl.lock_override}, 8'h01);
      pulse(lk_t[n]);
      @(negedge clk);
      check({7'h00, ctl.lock_override}, 8'h00);
    end
    wreg(C1, 8'h00);
    wreg(C1, 8'h08);
    wreg(C0, 8'h0E);
    idle(1);
    @(negedge clk);
    check({6'h00, ctl.flash_stop, ctl.lock_override}, 8'h02);
    wreg(C0, 8'h06);
    wreg(C0, 8'h16);
    rreg(C0, 8'h06);
    idle(1);
    @(negedge clk);
    check({7'h00, ctl.force_abort}, 8'h00);
    $display("test lock and stop done");
    start(8'd200);
    rreg(ST, 8'h00);
    wreg(C1, 8'h00);
    wreg(C1, 8'h08);
    wreg(C0, 8'h16);
    idle(1);
    @(negedge clk);
    check({5'h00, ctl.force_abort, ctl.clear_suspend, ctl.lock_override}, 8'h06);
    @(negedge clk);
    check({7'h00, ctl.clear_suspend}, 8'h00);
    n = 1;
    while (ctl.force_abort === 1'b1 && n < 50) begin
      n++;
      @(negedge clk);
    end
    check(8'(n), 8'(AB + 1));
    idle(3);
    rreg(ST, 8'h80);
    $display("test abort done");
    wreg(ST, 8'h00);
    wreg(C0, 8'h86);
    start(8'd5);
    idle(10);
    @(negedge clk);
    check({5'h00, rdy, acc, cmd}, 8'h04);
    rreg(ST, 8'h81);
    wreg(ST, 8'h02);
    idle(2);
    @(negedge clk);
    check({5'h00, rdy, acc, cmd}, 8'h00);
    rreg(ST, 8'h80);
    for (n = 0; n < 4; n++) begin
      wreg(C0, en_t[n]);
      pulse(src_t[n]);
      idle(3);
      @(negedge clk);
      check({5'h00, rdy, acc, cmd}, irq_t[n]);
      wreg(ST, 8'h00);
      idle(2);
      @(negedge clk);
      check({5'h00, rdy, acc, cmd}, 8'h00);
    end
    $display("test interrupts done");
    wreg(C1, 8'hF0);
    wreg(C0, 8'h00);
    wreg(C0, 8'h08);
    rreg(C1, 8'h00);
    rreg(C0, 8'h00);
    idle(3);
    $display("test disable done");
    print_verdict;
  end
endmodule
`default_nettype wire
